// file: clock_gate_pkg.sv
// constants for the sleep-mode clock gate register block
package clock_gate_pkg;
    localparam int          DATA_W          = 32;
    localparam int          ADDR_W          = 12;
    localparam int          UNIT_SEL_W      = 5;
    // register byte addresses
    localparam logic [11:0] SLEEP_GATE_OFF  = 12'h114;
    localparam logic [11:0] IRQ_STATUS_OFF  = 12'h200;
    localparam logic [11:0] IRQ_ENABLE_OFF  = 12'h204;
    localparam logic [11:0] IRQ_CLEAR_OFF   = 12'h208;
    // gate register layout
    localparam int          ANALOG_CMP0_BIT = 24;
    localparam int          GP_COUNTER0_BIT = 16;
    localparam int          TWO_WIRE0_BIT   = 12;
    localparam int          QUAD_DEC0_BIT   = 8;
    localparam int          SYNC_SER0_BIT   = 4;
    localparam int          ASYNC_SER0_BIT  = 0;
    localparam logic [31:0] GATE_WRITE_MASK = 32'h070f1137;
    localparam logic [31:0] GATE_RESET      = 32'h00000000;
    // interrupt layout
    localparam int          IRQ_W           = 2;
    localparam int          IRQ_FAULT_BIT   = 0;
    localparam int          IRQ_SLEEP_BIT   = 1;
    localparam logic [1:0]  IRQ_RESET       = 2'h0;
    localparam logic [31:0] READ_ZERO       = 32'h00000000;

    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_SLEEP,
        MODE_DEEP_SLEEP
    } power_mode_e;
endpackage : clock_gate_pkg

// file: gate_select.sv
// per-unit clock enable selection from the power mode
`timescale 1ns/1ps
module gate_select
    import clock_gate_pkg::*;
#(
    parameter int WIDTH = 32
) (
    input  wire logic                    sys_clk,            // system clock
    input  wire logic                    reset_n,            // sync reset, active low
    input  wire clock_gate_pkg::power_mode_e mode,           // current power mode
    input  wire logic                    auto_gating_select, // sleep gating in use
    input  wire logic [WIDTH-1:0]        run_gate,           // run-mode gates
    input  wire logic [WIDTH-1:0]        sleep_gate,         // sleep-mode gates
    input  wire logic [WIDTH-1:0]        deep_gate,          // deep-sleep gates
    output logic      [WIDTH-1:0]        unit_clk_en         // registered enables
);
    logic [WIDTH-1:0] next_unit_clk_en;

    // one selector per unit
    for (genvar i = 0; i < WIDTH; i++) begin : g_unit
        always_comb begin
            case (mode)
                MODE_SLEEP:      next_unit_clk_en[i] = auto_gating_select ? sleep_gate[i]
                                                                          : run_gate[i];
                MODE_DEEP_SLEEP: next_unit_clk_en[i] = auto_gating_select ? deep_gate[i]
                                                                          : run_gate[i];
                default:         next_unit_clk_en[i] = run_gate[i];
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            unit_clk_en <= '0;
        end else begin
            unit_clk_en <= next_unit_clk_en;
        end
    end
endmodule : gate_select

// file: gated_access_check.sv
// flags bus accesses aimed at a unit whose clock is off
`timescale 1ns/1ps
module gated_access_check
    import clock_gate_pkg::*;
#(
    parameter int WIDTH = 32
) (
    input  wire logic                  sys_clk,        // system clock
    input  wire logic                  reset_n,        // sync reset, active low
    input  wire logic                  unit_access,    // access strobe to a unit
    input  wire logic [UNIT_SEL_W-1:0] unit_target,    // gate bit index of target
    input  wire logic [WIDTH-1:0]      unit_clk_en,    // current enables
    output logic                       bus_fault       // one-cycle fault pulse
);
    logic next_bus_fault;

    always_comb begin
        next_bus_fault = unit_access && !unit_clk_en[unit_target];
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            bus_fault <= 1'b0;
        end else begin
            bus_fault <= next_bus_fault;
        end
    end
endmodule : gated_access_check

// file: sleep_clock_gate_register.sv
// sleep-mode clock gate register with apb access, gating and fault flags
`timescale 1ns/1ps
//
// Notes on behaviour
// R1: sleep delivers clock only where bit set
// R2: access to gated unit gives bus fault
// R3: reset clears every gate bit
// R4: this register governs sleep only
// R5: used only when auto gating selected
// R6: bits 26..24 gate analog comparators
// R7: bits 19..16 gate general counters
// R8: bit 12 two-wire, bit 8 decoder
// R9: bits 5..4 gate synchronous serial units
// R10: bits 2..0 gate asynchronous serial units
// R11: reserved bits read zero, read-only
// R12: reserved bits ignore writes
module sleep_clock_gate_register
    import clock_gate_pkg::*;
(
    input  wire logic                        sys_clk,            // 125 MHz clock
    input  wire logic                        reset_n,            // sync reset, active low
    input  wire logic                        psel,               // apb select
    input  wire logic                        penable,            // apb access phase
    input  wire logic                        pwrite,             // apb direction
    input  wire logic [clock_gate_pkg::ADDR_W-1:0] paddr,        // apb byte address
    input  wire logic [clock_gate_pkg::DATA_W-1:0] pwdata,       // apb write data
    output logic      [clock_gate_pkg::DATA_W-1:0] prdata,       // apb read data
    output logic                             pready,             // apb ready
    output logic                             pslverr,            // apb error
    input  wire clock_gate_pkg::power_mode_e mode,               // current power mode
    input  wire logic                        auto_gating_select, // from run clock config
    input  wire logic [clock_gate_pkg::DATA_W-1:0] run_gate,     // run-mode gates
    input  wire logic [clock_gate_pkg::DATA_W-1:0] deep_gate,    // deep-sleep gates
    input  wire logic                        unit_access,        // access strobe to a unit
    input  wire logic [clock_gate_pkg::UNIT_SEL_W-1:0] unit_target, // target gate index
    output logic      [clock_gate_pkg::DATA_W-1:0] unit_clk_en,  // per-unit clock enable
    output logic                             bus_fault,          // fault pulse to master
    output logic                             irq                 // level interrupt
);
    import clock_gate_pkg::*;

    logic [DATA_W-1:0] sleep_clock_gate_ctrl_1;
    logic [DATA_W-1:0] next_sleep_clock_gate_ctrl_1;
    logic [IRQ_W-1:0]  irq_status;
    logic [IRQ_W-1:0]  next_irq_status;
    logic [IRQ_W-1:0]  irq_enable;
    logic [IRQ_W-1:0]  next_irq_enable;
    logic [DATA_W-1:0] next_prdata;
    logic              access;
    logic              wr;
    logic              mapped;
    logic              sleep_active;
    logic              sleep_active_d;
    logic              next_sleep_active_d;
    logic [IRQ_W-1:0]  irq_events;
    logic [IRQ_W-1:0]  irq_clear;

    // apb decode, zero-wait answer
    always_comb begin
        access = psel && penable;
        wr     = access && pwrite;
        pready = 1'b1;
        case (paddr)
            SLEEP_GATE_OFF, IRQ_STATUS_OFF, IRQ_ENABLE_OFF, IRQ_CLEAR_OFF: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // gate register write path
    always_comb begin
        next_sleep_clock_gate_ctrl_1 = sleep_clock_gate_ctrl_1;
        if (wr && paddr == SLEEP_GATE_OFF) begin
            // R6 R7 R8 R9 R10 R12: only gate bits take data
            next_sleep_clock_gate_ctrl_1 = pwdata & GATE_WRITE_MASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            // R3: all units start unclocked
            sleep_clock_gate_ctrl_1 <= GATE_RESET;
        end else begin
            sleep_clock_gate_ctrl_1 <= next_sleep_clock_gate_ctrl_1;
        end
    end

    // read path: captured in the setup cycle so it stands through the access phase
    always_comb begin
        next_prdata = prdata;
        if (psel && !penable) begin
            next_prdata = READ_ZERO;
            if (!pwrite) begin
                case (paddr)
                    // R11: reserved bits read zero
                    SLEEP_GATE_OFF: next_prdata = sleep_clock_gate_ctrl_1 & GATE_WRITE_MASK;
                    IRQ_STATUS_OFF: next_prdata = {{(DATA_W-IRQ_W){1'b0}}, irq_status};
                    IRQ_ENABLE_OFF: next_prdata = {{(DATA_W-IRQ_W){1'b0}}, irq_enable};
                    default:        next_prdata = READ_ZERO;
                endcase
            end
        end
    end

    // status snapshot taken at setup; a later event stays sticky for the next read
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            prdata <= READ_ZERO;
        end else begin
            prdata <= next_prdata;
        end
    end

    // error only during the access phase
    always_comb begin
        pslverr = access && !mapped;
    end

    // R1 R4 R5: mode and auto gating pick the gate source
    gate_select #(
        .WIDTH              (DATA_W)
    ) u_gate_select (
        .sys_clk            (sys_clk),
        .reset_n            (reset_n),
        .mode               (mode),
        .auto_gating_select (auto_gating_select),
        .run_gate           (run_gate),
        .sleep_gate         (sleep_clock_gate_ctrl_1),
        .deep_gate          (deep_gate),
        .unit_clk_en        (unit_clk_en)
    );

    // R2: fault on access to an unclocked unit
    gated_access_check #(
        .WIDTH       (DATA_W)
    ) u_access_check (
        .sys_clk     (sys_clk),
        .reset_n     (reset_n),
        .unit_access (unit_access),
        .unit_target (unit_target),
        .unit_clk_en (unit_clk_en),
        .bus_fault   (bus_fault)
    );

    // interrupt events: fault and sleep gating taking effect
    always_comb begin
        sleep_active        = (mode == MODE_SLEEP) && auto_gating_select;
        next_sleep_active_d = sleep_active;
        irq_events          = '0;
        irq_events[IRQ_FAULT_BIT] = bus_fault;
        irq_events[IRQ_SLEEP_BIT] = sleep_active && !sleep_active_d;
        irq_clear = (wr && paddr == IRQ_CLEAR_OFF) ? pwdata[IRQ_W-1:0] : '0;
        // set beats clear in the same cycle
        next_irq_status = (irq_status & ~irq_clear) | irq_events;
        next_irq_enable = (wr && paddr == IRQ_ENABLE_OFF) ? pwdata[IRQ_W-1:0] : irq_enable;
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            irq_status     <= IRQ_RESET;
            irq_enable     <= IRQ_RESET;
            sleep_active_d <= 1'b0;
            irq            <= 1'b0;
        end else begin
            irq_status     <= next_irq_status;
            irq_enable     <= next_irq_enable;
            sleep_active_d <= next_sleep_active_d;
            irq            <= |(next_irq_status & next_irq_enable);
        end
    end

    // checks
    sequence gate_write_s;
        psel && penable && pwrite && paddr == SLEEP_GATE_OFF;
    endsequence

    sequence sleep_steady_s;
        mode == MODE_SLEEP && auto_gating_select ##1
        mode == MODE_SLEEP && auto_gating_select && $stable(sleep_clock_gate_ctrl_1);
    endsequence

    reset_clears_gates_a: assert property ( // R3
        @(posedge sys_clk) !reset_n |=> sleep_clock_gate_ctrl_1 == GATE_RESET)
        else $error("gate register not cleared by reset");

    gate_write_takes_a: assert property ( // R6
        @(posedge sys_clk) disable iff (!reset_n)
        gate_write_s |=> sleep_clock_gate_ctrl_1 == ($past(pwdata) & GATE_WRITE_MASK))
        else $error("gate register write lost or unmasked");

    reserved_read_zero_a: assert property ( // R11
        @(posedge sys_clk) disable iff (!reset_n)
        psel && penable && !pwrite && paddr == SLEEP_GATE_OFF
        |-> (prdata & ~GATE_WRITE_MASK) == READ_ZERO)
        else $error("reserved bits read nonzero");

    reserved_no_store_a: assert property ( // R12
        @(posedge sys_clk) disable iff (!reset_n)
        (sleep_clock_gate_ctrl_1 & ~GATE_WRITE_MASK) == READ_ZERO)
        else $error("reserved bit stored");

    gates_hold_a: assert property ( // R3
        @(posedge sys_clk) disable iff (!reset_n)
        !(wr && paddr == SLEEP_GATE_OFF) |=> $stable(sleep_clock_gate_ctrl_1))
        else $error("gate register changed without a write");

    sleep_gates_apply_a: assert property ( // R1
        @(posedge sys_clk) disable iff (!reset_n)
        sleep_steady_s |-> unit_clk_en == sleep_clock_gate_ctrl_1)
        else $error("sleep gates not applied in sleep");

    run_ignores_sleep_a: assert property ( // R4
        @(posedge sys_clk) disable iff (!reset_n)
        mode == MODE_RUN |=> unit_clk_en == $past(run_gate))
        else $error("run mode not using run gates");

    no_auto_uses_run_a: assert property ( // R5
        @(posedge sys_clk) disable iff (!reset_n)
        !auto_gating_select |=> unit_clk_en == $past(run_gate))
        else $error("sleep gates used without auto gating");

    gated_fault_a: assert property ( // R2
        @(posedge sys_clk) disable iff (!reset_n)
        unit_access && !unit_clk_en[unit_target] |=> bus_fault)
        else $error("no bus fault on access to a gated unit");

    no_fault_clocked_a: assert property ( // R2
        @(posedge sys_clk) disable iff (!reset_n)
        !(unit_access && !unit_clk_en[unit_target]) |=> !bus_fault)
        else $error("bus fault without a gated access");

    fault_flag_sets_a: assert property ( // R2
        @(posedge sys_clk) disable iff (!reset_n)
        bus_fault |=> irq_status[IRQ_FAULT_BIT] ##0 (irq == irq_enable[IRQ_FAULT_BIT]
                                                     || irq))
        else $error("fault status not raised");

    read_data_stands_a: assert property ( // R11
        @(posedge sys_clk) disable iff (!reset_n)
        psel && penable && !pwrite && paddr == SLEEP_GATE_OFF
        |-> prdata == (sleep_clock_gate_ctrl_1 & GATE_WRITE_MASK))
        else $error("gate read data not standing in access phase");

    counter_gate_write_a: assert property ( // R7
        @(posedge sys_clk) disable iff (!reset_n)
        gate_write_s |=> sleep_clock_gate_ctrl_1[GP_COUNTER0_BIT]
                         == $past(pwdata[GP_COUNTER0_BIT]))
        else $error("counter gate bit not written");

    two_wire_write_a: assert property ( // R8
        @(posedge sys_clk) disable iff (!reset_n)
        gate_write_s |=> sleep_clock_gate_ctrl_1[TWO_WIRE0_BIT]
                         == $past(pwdata[TWO_WIRE0_BIT]))
        else $error("two-wire gate bit not written");

    decoder_write_a: assert property ( // R8
        @(posedge sys_clk) disable iff (!reset_n)
        gate_write_s |=> sleep_clock_gate_ctrl_1[QUAD_DEC0_BIT]
                         == $past(pwdata[QUAD_DEC0_BIT]))
        else $error("decoder gate bit not written");

    sync_serial_write_a: assert property ( // R9
        @(posedge sys_clk) disable iff (!reset_n)
        gate_write_s |=> sleep_clock_gate_ctrl_1[SYNC_SER0_BIT]
                         == $past(pwdata[SYNC_SER0_BIT]))
        else $error("synchronous serial gate bit not written");

    async_serial_write_a: assert property ( // R10
        @(posedge sys_clk) disable iff (!reset_n)
        gate_write_s |=> sleep_clock_gate_ctrl_1[ASYNC_SER0_BIT]
                         == $past(pwdata[ASYNC_SER0_BIT]))
        else $error("asynchronous serial gate bit not written");

    deep_ignores_sleep_a: assert property ( // R4
        @(posedge sys_clk) disable iff (!reset_n)
        mode == MODE_DEEP_SLEEP && auto_gating_select |=> unit_clk_en == $past(deep_gate))
        else $error("deep sleep not using deep gates");

    zero_wait_ready_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        psel && penable |-> pready)
        else $error("access phase not answered at once");

    unmapped_error_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        psel && penable |-> pslverr == !mapped)
        else $error("error response does not match decode");

    fault_status_sticky_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        irq_status[IRQ_FAULT_BIT] && !irq_clear[IRQ_FAULT_BIT] |=> irq_status[IRQ_FAULT_BIT])
        else $error("fault status lost without a clear");

    irq_level_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        irq == |(irq_status & irq_enable))
        else $error("interrupt level does not follow enabled status");

    sleep_event_sets_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        sleep_active && !sleep_active_d |=> irq_status[IRQ_SLEEP_BIT])
        else $error("sleep gating event not recorded");
endmodule : sleep_clock_gate_register

// file: unit_access_model.sv
// far-side model issuing unit accesses and watching the fault answer
`timescale 1ns/1ps
module unit_access_model
    import clock_gate_pkg::*;
(
    input  wire logic                                  sys_clk,     // system clock
    input  wire logic                                  bus_fault,   // fault answer
    output logic                                       unit_access, // access strobe
    output logic [clock_gate_pkg::UNIT_SEL_W-1:0]      unit_target  // target gate index
);
    initial begin
        unit_access = 1'b0;
        unit_target = 5'h00;
    end
    // one access, fault looked at next cycle
    task automatic poke(input logic [4:0] t, output logic f, output logic f2);
        @(posedge sys_clk);
        unit_access <= 1'b1;
        unit_target <= t;
        @(posedge sys_clk);
        unit_access <= 1'b0;
        unit_target <= ~t;
        #1 f = bus_fault;
        @(posedge sys_clk);
        #1 f2 = bus_fault;
    endtask : poke
endmodule : unit_access_model

// file: sleep_clock_gate_register_test.sv
// self-checking bench for the sleep-mode clock gate register
`timescale 1ns/1ps
module sleep_clock_gate_register_test;
    import clock_gate_pkg::*;
    typedef struct {logic [31:0] wv; logic [31:0] ev; logic [4:0] tg;} row_s;
    logic        sys_clk, reset_n, psel, penable, pwrite, pready, pslverr;
    logic        auto_gating_select, unit_access, bus_fault, irq, f, f2, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, run_gate, deep_gate, unit_clk_en, rd;
    logic [4:0]  unit_target;
    power_mode_e mode;
    int          miscompares, comparisons;
    row_s        rows [8];

    sleep_clock_gate_register i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mode(mode),
        .auto_gating_select(auto_gating_select), .run_gate(run_gate), .deep_gate(deep_gate),
        .unit_access(unit_access), .unit_target(unit_target), .unit_clk_en(unit_clk_en),
        .bus_fault(bus_fault), .irq(irq));
    unit_access_model i_far (.sys_clk(sys_clk), .bus_fault(bus_fault),
        .unit_access(unit_access), .unit_target(unit_target));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic end_of_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick

    // apb transfer; read data and error taken at the ready edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        err = pslverr;
        rd  = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            miscompares++;
            end_of_test();
        end
    endtask : apb

    initial begin
        {psel, penable, pwrite, auto_gating_select} = 4'h0;
        {paddr, pwdata, miscompares, comparisons} = '0;
        reset_n   = 1'b0;
        mode      = MODE_RUN;
        run_gate  = 32'h00000055;
        deep_gate = 32'h0a0a0a0a;
        rows = '{'{32'hffffffff, 32'h070f1137, 5'd26}, '{32'h07000000, 32'h07000000, 5'd24},
                 '{32'h000f0000, 32'h000f0000, 5'd19}, '{32'h00001100, 32'h00001100, 5'd8},
                 '{32'h00000030, 32'h00000030, 5'd5},  '{32'h00000007, 32'h00000007, 5'd2},
                 '{32'hf8f0eec8, 32'h00000000, 5'd12}, '{32'h00000000, 32'h00000000, 5'd0}};
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        apb(1'b0, SLEEP_GATE_OFF, 32'h0);
        check("gate reset", rd, GATE_RESET);
        check("read no error", {31'h0, err}, 32'h0);
        check("irq reset", {31'h0, irq}, 32'h0);
        mode               <= MODE_SLEEP;
        auto_gating_select <= 1'b1;
        apb(1'b1, IRQ_CLEAR_OFF, 32'h3);
        apb(1'b1, IRQ_ENABLE_OFF, 32'h1);
        foreach (rows[i]) begin
            apb(1'b1, SLEEP_GATE_OFF, rows[i].wv);
            apb(1'b0, SLEEP_GATE_OFF, 32'h0);
            check("gate readback", rd, rows[i].ev);
            tick(1);
            check("sleep enables", unit_clk_en, rows[i].ev);
            i_far.poke(rows[i].tg, f, f2);
            check("fault pulse", {31'h0, f}, {31'h0, ~rows[i].ev[rows[i].tg]});
            check("fault one cycle", {31'h0, f2}, 32'h0);
        end
        tick(2);
        check("irq raised", {31'h0, irq}, 32'h1);
        apb(1'b0, IRQ_STATUS_OFF, 32'h0);
        check("status fault", rd & 32'h1, 32'h1);
        apb(1'b1, IRQ_CLEAR_OFF, 32'h3);
        tick(2);
        check("irq cleared", {31'h0, irq}, 32'h0);
        apb(1'b1, IRQ_ENABLE_OFF, 32'h0);
        i_far.poke(5'd1, f, f2);
        tick(2);
        check("irq masked", {31'h0, irq}, 32'h0);
        apb(1'b1, 12'h300, 32'hffffffff);
        check("unmapped error", {31'h0, err}, 32'h1);
        apb(1'b1, SLEEP_GATE_OFF, 32'h070f1137);
        mode <= MODE_RUN;
        tick(3);
        check("run enables", unit_clk_en, run_gate);
        mode               <= MODE_SLEEP;
        auto_gating_select <= 1'b0;
        tick(3);
        check("no auto enables", unit_clk_en, run_gate);
        mode               <= MODE_DEEP_SLEEP;
        auto_gating_select <= 1'b1;
        tick(3);
        check("deep enables", unit_clk_en, deep_gate);
        mode <= MODE_SLEEP;
        tick(3);
        check("sleep again", unit_clk_en, 32'h070f1137);
        reset_n <= 1'b0;
        tick(2);
        reset_n <= 1'b1;
        apb(1'b0, SLEEP_GATE_OFF, 32'h0);
        check("gate second reset", rd, GATE_RESET);
        check("enables second reset", unit_clk_en, 32'h0);
        check("irq second reset", {31'h0, irq}, 32'h0);
        end_of_test();
    end
endmodule : sleep_clock_gate_register_test
